// file: hw/stm_pkg.sv
// Shared types and constants of the sample to lane mapper
package stm_pkg;

    localparam int SMP_W    = 9;    // Converter sample width
    localparam int NUM_CH   = 4;    // Channels A..D
    localparam int SMP_PER  = 4;    // Samples per channel per frame
    localparam int MAX_LANE = 8;
    localparam int MAX_OCT  = 5;
    localparam int LANE_W   = MAX_OCT * 8;
    localparam int CONT_W   = 12;   // Sample plus three zero bits
    localparam int PAIR_W   = 4 * CONT_W;

    // Link mode codes
    localparam logic [3:0] MODE_1 = 4'h1;
    localparam logic [3:0] MODE_2 = 4'h2;
    localparam logic [3:0] MODE_3 = 4'h3;
    localparam logic [3:0] MODE_4 = 4'h4;
    localparam logic [3:0] MODE_5 = 4'h5;
    localparam logic [3:0] MODE_6 = 4'h6;
    localparam logic [3:0] MODE_7 = 4'h7;
    localparam logic [3:0] MODE_8 = 4'h8;
    localparam logic [3:0] MODE_9 = 4'h9;

    // Octets used per lane and frame
    localparam logic [2:0] OCT_ONE   = 3'h1;
    localparam logic [2:0] OCT_TWO   = 3'h2;
    localparam logic [2:0] OCT_THREE = 3'h3;
    localparam logic [2:0] OCT_FIVE  = 3'h5;

    typedef enum logic [1:0]
    {
        STM_QUAD   = 2'h0,
        STM_DUAL   = 2'h1,
        STM_SINGLE = 2'h2
    } stm_variant_t;

    typedef struct packed
    {
        logic [NUM_CH-1:0][SMP_PER-1:0][SMP_W-1:0] smp;
    } stm_frame_in_t;

    typedef struct packed
    {
        logic [MAX_LANE-1:0][LANE_W-1:0] lane;
        logic [3:0]                      lane_cnt;
        logic [2:0]                      oct_cnt;
    } stm_frame_out_t;

endpackage

// file: hw/stm_mapper.sv
// Sample to lane transport mapper with two-entry output buffer
//
// Operation
// - Mode 1 splits 9-bit samples plus three zeros over 6/3/2 lanes.
// - Mode 2 puts one 8-bit sample per octet, lane n carrying channel n.
// - Mode 3 packs four 9-bit samples, each plus a zero, in five octets.
// - Mode 4 packs one padded sample per channel over 3/2/1 lanes.
// - Mode 5 sends A,B on lane 0 and C,D on lane 1, zero for missing B.
// - Mode 6 uses the mode 1 split layout, zero for the missing channel.
// - Mode 7 sends one 8-bit sample per octet, one lane per channel.
// - Mode 8 sends two 12-bit containers of a channel per three octets.
// - Mode 9 gives each channel two lanes, even then odd samples.
`timescale 1ns/1ns
module stm_mapper
    import stm_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input  wire logic           clk_sys,
    input  wire logic           srst,
    input  wire logic [3:0]     link_mode_select,
    input  wire stm_variant_t   variant,
    input  wire logic           in_valid,
    output logic                in_ready,
    input  wire stm_frame_in_t  in_data,
    output logic                out_valid,
    input  wire logic           out_ready,
    output stm_frame_out_t      out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [CONT_W-1:0] cont12(input logic [SMP_W-1:0] s);
        cont12 = {s, 3'h0};
    endfunction

    function automatic logic [7:0] byte8(input logic [SMP_W-1:0] s);
        byte8 = s[SMP_W-1:1];
    endfunction

    function automatic logic [3:0] lanes_of(input logic [3:0] m,
                                            input stm_variant_t v);
        logic [3:0] q;
        q = 4'h0;
        unique case (m)
            MODE_1, MODE_6: q = 4'h6;
            MODE_2, MODE_3, MODE_7, MODE_8: q = 4'h4;
            MODE_4: q = 4'h3;
            MODE_5: q = 4'h2;
            MODE_9: q = 4'h8;
            default: q = 4'h0;
        endcase
        unique case (v)
            STM_QUAD:   lanes_of = q;
            STM_DUAL:   lanes_of = (m == MODE_4) ? 4'h2 : q >> 1;
            STM_SINGLE: lanes_of = (m == MODE_1 || m == MODE_6 ||
                                    m == MODE_9) ? 4'h2 : ((q == 4'h0) ?
                                    4'h0 : 4'h1);
            default:    lanes_of = 4'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Channel gating by variant
    // ------------------------------------------------------------
    logic [NUM_CH-1:0][SMP_PER-1:0][SMP_W-1:0] g;
    logic [2:0]                                nch;

    always_comb
    begin
        unique case (variant)
            STM_QUAD:   nch = 3'h4;
            STM_DUAL:   nch = 3'h2;
            default:    nch = 3'h1;
        endcase
        for (int c = 0; c < NUM_CH; c++)
        begin
            g[c] = (3'(c) < nch) ? in_data.smp[c] : '0;
        end
    end

    // ------------------------------------------------------------
    // Lane mapping, first bit sent at the top of each lane
    // ------------------------------------------------------------
    stm_frame_out_t map_d;

    always_comb
    begin
        logic [PAIR_W-1:0] pk;
        pk = '0;
        map_d = '0;
        map_d.lane_cnt = lanes_of(link_mode_select, variant);
        unique case (link_mode_select)
            MODE_1, MODE_6:
            begin
                map_d.oct_cnt = OCT_TWO;
                for (int p = 0; p < 2; p++)
                begin
                    pk = {cont12(g[2*p][0]), cont12(g[2*p][1]),
                          cont12(g[2*p+1][0]), cont12(g[2*p+1][1])};
                    for (int k = 0; k < 3; k++)
                    begin
                        map_d.lane[3*p+k][LANE_W-1 -: 16] =
                            pk[PAIR_W-1-16*k -: 16];
                    end
                end
            end
            MODE_2, MODE_7:
            begin
                map_d.oct_cnt = OCT_ONE;
                for (int c = 0; c < NUM_CH; c++)
                begin
                    map_d.lane[c][LANE_W-1 -: 8] =
                        byte8(g[c][0]);
                end
            end
            MODE_3:
            begin
                map_d.oct_cnt = OCT_FIVE;
                for (int c = 0; c < NUM_CH; c++)
                begin
                    map_d.lane[c] = {g[c][0], 1'b0, g[c][1], 1'b0,
                                     g[c][2], 1'b0, g[c][3], 1'b0};
                end
            end
            MODE_4:
            begin
                map_d.oct_cnt = OCT_TWO;
                pk = {cont12(g[0][0]), cont12(g[1][0]),
                      cont12(g[2][0]), cont12(g[3][0])};
                for (int k = 0; k < 3; k++)
                begin
                    map_d.lane[k][LANE_W-1 -: 16] =
                        pk[PAIR_W-1-16*k -: 16];
                end
            end
            MODE_5:
            begin
                map_d.oct_cnt = OCT_TWO;
                for (int p = 0; p < 2; p++)
                begin
                    map_d.lane[p][LANE_W-1 -: 16] =
                        {byte8(g[2*p][0]), byte8(g[2*p+1][0])};
                end
            end
            MODE_8:
            begin
                map_d.oct_cnt = OCT_THREE;
                for (int c = 0; c < NUM_CH; c++)
                begin
                    map_d.lane[c][LANE_W-1 -: 24] =
                        {cont12(g[c][0]), cont12(g[c][1])};
                end
            end
            MODE_9:
            begin
                map_d.oct_cnt = OCT_ONE;
                for (int c = 0; c < NUM_CH; c++)
                begin
                    map_d.lane[2*c][LANE_W-1 -: 8]   = byte8(g[c][0]);
                    map_d.lane[2*c+1][LANE_W-1 -: 8] = byte8(g[c][1]);
                end
            end
            default:
            begin
                map_d = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Two-entry buffer
    // ------------------------------------------------------------
    stm_frame_out_t    mem_q [DEPTH];
    logic [PW-1:0]     wr_ptr_q;
    logic [PW-1:0]     rd_ptr_q;
    logic [CW-1:0]     cnt_q;
    logic              push;
    logic              pop;

    assign in_ready  = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q];

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= map_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_take_empty;
        push && (cnt_q == '0);
    endsequence

    sequence s_show(stm_frame_out_t f);
        out_valid && (out_data == f);
    endsequence

    AST_PASS: assert property (s_take_empty |=> s_show($past(map_d)))
        else $error("Accepted frame not shown next cycle");
    AST_HOLD: assert property ((out_valid && !out_ready) |=>
                               (out_valid && $stable(out_data)))
        else $error("Stalled frame changed");
    AST_M1: assert property ((link_mode_select == MODE_1) |->
        map_d.lane[1][LANE_W-1 -: 8] == {g[0][1][4:0], 3'h0})
        else $error("Mode 1 split sample wrong");
    AST_M2: assert property ((link_mode_select == MODE_2) |->
        map_d.lane[1][LANE_W-1 -: 8] == g[1][0][8:1])
        else $error("Mode 2 lane 1 wrong");
    AST_M3: assert property ((link_mode_select == MODE_3) |->
        map_d.lane[0][8:0] == {g[0][3][7:0], 1'b0})
        else $error("Mode 3 last octet wrong");
    AST_M4: assert property ((link_mode_select == MODE_4) |->
        map_d.lane[2][LANE_W-1 -: 16] == {g[2][0][0], 3'h0, g[3][0], 3'h0})
        else $error("Mode 4 lane 2 wrong");
    AST_M5: assert property ((link_mode_select == MODE_5 &&
        variant == STM_SINGLE) |-> map_d.lane[0][31:24] == 8'h00)
        else $error("Mode 5 single filler not zero");
    AST_M6: assert property ((link_mode_select == MODE_6 &&
        variant == STM_SINGLE) |-> map_d.lane[1][31:24] == 8'h00 &&
        map_d.lane_cnt == 4'h2)
        else $error("Mode 6 single layout wrong");
    AST_M7: assert property ((link_mode_select == MODE_7) |->
        map_d.lane[3][LANE_W-1 -: 8] == g[3][0][8:1])
        else $error("Mode 7 lane 3 wrong");
    AST_M8: assert property ((link_mode_select == MODE_8) |->
        map_d.lane[0][27:16] == {g[0][1], 3'h0} &&
        map_d.oct_cnt == OCT_THREE)
        else $error("Mode 8 second container wrong");
    AST_M9: assert property ((link_mode_select == MODE_9) |->
        map_d.lane[5][LANE_W-1 -: 8] == g[2][1][8:1])
        else $error("Mode 9 odd sample lane wrong");

endmodule

// file: sim/stm_sink.sv
// Receiving logic model that takes mapped frames
`timescale 1ns/1ns
module stm_sink
    import stm_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           srst,
    input  wire logic           stall,
    input  wire logic           slow,
    input  wire logic           out_valid,
    output logic                out_ready,
    input  wire stm_frame_out_t out_data
);
    stm_frame_out_t rx_q[$];
    // ----
    // Capture and pacing
    // ----
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            out_ready <= 1'b0;
            rx_q.delete();
        end
        else
        begin
            if (out_valid && out_ready)
                rx_q.push_back(out_data);
            out_ready <= !stall && !(slow && out_ready);
        end
    end
endmodule

// file: sim/test_stm_mapper.sv
// Self-checking bench of the sample to lane mapper
`timescale 1ns/1ns
module test_stm_mapper
    import stm_pkg::*;
;
    typedef struct
    {
        logic [3:0]     m;
        stm_variant_t   v;
        stm_frame_in_t  d;
        stm_frame_out_t x;
    } stm_row_t;
    localparam int LN[3][9] = '{'{6, 4, 4, 3, 2, 6, 4, 4, 8},
        '{3, 2, 2, 2, 1, 3, 2, 2, 4}, '{2, 1, 1, 1, 1, 2, 1, 1, 2}};
    localparam int OC[9] = '{2, 1, 5, 2, 2, 2, 1, 3, 1};
    logic           clk_sys, srst, in_valid, stall, slow;
    logic [3:0]     mode;
    stm_variant_t   vr;
    stm_frame_in_t  din;
    logic           in_ready, out_valid, out_ready;
    stm_frame_out_t dout, f, e;
    int             n_fail, comparisons;
    stm_row_t       rows[30];

    stm_mapper stm_mapper_i (.clk_sys(clk_sys), .srst(srst),
        .link_mode_select(mode), .variant(vr), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(din), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(dout));
    stm_sink stm_sink_i (.clk_sys(clk_sys), .srst(srst), .stall(stall),
        .slow(slow), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(dout));

    // ----
    // Reference mapping and helpers
    // ----
    function automatic logic [11:0] c12(logic [8:0] s);
        return {s, 3'h0};
    endfunction

    function automatic stm_frame_out_t ref_map(logic [3:0] m,
        stm_variant_t v, stm_frame_in_t d);
        stm_frame_out_t r;
        logic [47:0]    w;
        r = '0;
        for (int c = 1; c < 4; c++)
            if ((c > 1 && v != STM_QUAD) || v == STM_SINGLE)
                d.smp[c] = '0;
        for (int p = 0; p < 3; p++)
        begin
            w = {c12(d.smp[2*p%4][0]), c12(d.smp[2*p%4][1]),
                c12(d.smp[2*p%4+1][0]), c12(d.smp[2*p%4+1][1])};
            if (m == MODE_4)
                w = {c12(d.smp[0][0]), c12(d.smp[1][0]),
                    c12(d.smp[2][0]), c12(d.smp[3][0])};
            for (int k = 0; k < 3; k++)
                if ((m == MODE_1 || m == MODE_6) && p < 2)
                    r.lane[3*p+k][39:24] = w[47-16*k -: 16];
                else if (m == MODE_4 && p == 2)
                    r.lane[k][39:24] = w[47-16*k -: 16];
        end
        for (int c = 0; c < 4; c++)
            case (m)
                MODE_2, MODE_7: r.lane[c][39:32] = d.smp[c][0][8:1];
                MODE_3: r.lane[c] = {d.smp[c][0], 1'b0, d.smp[c][1], 1'b0,
                    d.smp[c][2], 1'b0, d.smp[c][3], 1'b0};
                MODE_5: r.lane[c/2][39-8*(c%2) -: 8] = d.smp[c][0][8:1];
                MODE_8: r.lane[c][39:16] = {c12(d.smp[c][0]),
                    c12(d.smp[c][1])};
                MODE_9: {r.lane[2*c][39:32], r.lane[2*c+1][39:32]} =
                    {d.smp[c][0][8:1], d.smp[c][1][8:1]};
                default: ;
            endcase
        if (m >= MODE_1 && m <= MODE_9)
        begin
            r.lane_cnt = 4'(LN[v][m-1]);
            r.oct_cnt = 3'(OC[m-1]);
        end
        return r;
    endfunction

    task automatic check(logic [326:0] got, logic [326:0] exp, string s);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, s);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic push(logic [3:0] m, stm_variant_t v, stm_frame_in_t d);
        mode = m;
        vr = v;
        din = d;
        in_valid = 1'b1;
        for (int k = 0; k < 50 && in_ready !== 1'b1; k++)
            @(negedge clk_sys);
        if (in_ready !== 1'b1)
        begin
            n_fail++;
            stop_test();
        end
        else
            @(negedge clk_sys);
    endtask

    task automatic get();
        for (int k = 0; k < 100 && stm_sink_i.rx_q.size() == 0; k++)
            @(negedge clk_sys);
        if (stm_sink_i.rx_q.size() == 0)
        begin
            n_fail++;
            stop_test();
        end
        else
            f = stm_sink_i.rx_q.pop_front();
    endtask

    // ----
    // Clock and sequence
    // ----
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial
    begin
        {srst, in_valid, stall, slow, mode, din} = '1;
        {in_valid, stall, slow, mode, din, n_fail, comparisons} = '0;
        vr = STM_QUAD;
        for (int i = 0; i < 30; i++)
        begin
            rows[i].m = 4'(i / 3);
            rows[i].v = stm_variant_t'(i % 3);
            for (int c = 0; c < 16; c++)
                rows[i].d.smp[c/4][c%4] = 9'(i * 41 + c * 23 + 9'h1b3);
            rows[i].x = ref_map(rows[i].m, rows[i].v, rows[i].d);
        end
        repeat (8) @(negedge clk_sys);
        srst = 1'b0;
        check(in_ready, 1'b1, "ready after reset");
        check(out_valid, 1'b0, "valid after reset");
        foreach (rows[i])
        begin
            slow = 1'(i % 2);
            push(rows[i].m, rows[i].v, rows[i].d);
            in_valid = 1'b0;
            get();
            e = rows[i].x;
            case (rows[i].m)
                MODE_1: check(f, e, "m1");
                MODE_2: check(f, e, "m2");
                MODE_3: check(f, e, "m3");
                MODE_4: check(f, e, "m4");
                MODE_5: check(f, e, "m5");
                MODE_6: check(f, e, "m6");
                MODE_7: check(f, e, "m7");
                MODE_8: check(f, e, "m8");
                MODE_9: check(f, e, "m9");
                default: check(f, e, "bad mode");
            endcase
        end
        $display("table test done");
        stall = 1'b1;
        push(MODE_3, STM_QUAD, rows[29].d);
        push(MODE_8, STM_DUAL, rows[28].d);
        repeat (3) @(negedge clk_sys);
        check(in_ready, 1'b0, "full refuses");
        check(out_valid, 1'b1, "held while stalled");
        stall = 1'b0;
        push(MODE_5, STM_SINGLE, rows[27].d);
        in_valid = 1'b0;
        get();
        check(f, ref_map(MODE_3, STM_QUAD, rows[29].d), "q0");
        get();
        check(f, ref_map(MODE_8, STM_DUAL, rows[28].d), "q1");
        get();
        check(f, ref_map(MODE_5, STM_SINGLE, rows[27].d), "q2");
        $display("backpressure test done");
        stall = 1'b1;
        push(MODE_2, STM_QUAD, rows[5].d);
        in_valid = 1'b0;
        srst = 1'b1;
        @(negedge clk_sys);
        srst = 1'b0;
        stall = 1'b0;
        check(out_valid, 1'b0, "valid after second reset");
        check(in_ready, 1'b1, "ready after second reset");
        push(MODE_9, STM_DUAL, rows[7].d);
        in_valid = 1'b0;
        get();
        check(f, ref_map(MODE_9, STM_DUAL, rows[7].d), "after reset");
        push(MODE_7, stm_variant_t'(2'h3), rows[3].d);
        in_valid = 1'b0;
        get();
        e = ref_map(MODE_7, STM_SINGLE, rows[3].d);
        e.lane_cnt = 4'h0;
        check(f, e, "spare variant code");
        $display("reset test done");
        stop_test();
    end
endmodule
